// *** design/bcp_top.sv ***
`timescale 1ns/1ps
// How it works
// - Hall A high decodes three drive steps
// - Hall A low decodes three drive steps
// - Invalid hall patterns turn all gates off
// - Tach outputs: hall A and hall majority
// - Duty from speed command versus sawtooth
// - Chop high side only, low side steady
// - Current limit kills all high sides
// - Current limit latch clears each period
// - Over-current turns all six gates off unless internal_rail is high
// - Over-current recovers after fixed interval
// - Command below floor stops high sides
module bcp_top #(
  parameter int OC_RECOVERY = bcp_pkg::OC_RECOVERY_CYC,
  parameter int PWM_PERIOD = bcp_pkg::PWM_PERIOD_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic hall_a,
  input wire logic hall_b,
  input wire logic hall_c,
  input wire logic current_limit_level,
  input wire logic overcurrent_level,
  input wire logic internal_rail,
  output logic [5:0] gate,
  output logic tach_single_out,
  output logic tach_majority_out,
  output logic pwm_clock_monitor,
  output logic irq
);
  // Bus registers
  logic [31:0] ctrl;
  logic [7:0] speed_command;
  logic [bcp_pkg::EV_W-1:0] irq_stat;
  logic [bcp_pkg::EV_W-1:0] irq_mask;
  logic wr_pend;
  logic [7:0] wr_addr;

  // Core state
  logic cl_latch;
  bcp_pkg::bcp_oc_state_t oc_state;
  logic [$clog2(OC_RECOVERY+1)-1:0] oc_cnt;
  logic [5:0] gate_raw;
  logic hall_invalid;
  logic hall_invalid_q;
  logic pwm_on;
  logic period_start;
  logic [7:0] sawtooth_node;
  logic tach_single;
  logic tach_majority;

  bcp_commutator u_comm (
    .hall_a(hall_a),
    .hall_b(hall_b),
    .hall_c(hall_c),
    .gate_raw(gate_raw),
    .tach_single(tach_single),
    .tach_majority(tach_majority),
    .hall_invalid(hall_invalid)
  );

  bcp_pwm #(.PERIOD(PWM_PERIOD)) u_pwm (
    .hclk(hclk),
    .hresetn(hresetn),
    .speed_command(speed_command),
    .pwm_on(pwm_on),
    .period_start(period_start),
    .sawtooth_node(sawtooth_node)
  );

  // Protection
  wire logic oc_enable = ctrl[bcp_pkg::CTRL_OC_EN] & ~internal_rail;
  wire logic oc_trip = oc_enable & overcurrent_level;
  wire logic in_fault = (oc_state == bcp_pkg::BCP_FAULT) | oc_trip;
  wire logic below_floor = speed_command < bcp_pkg::SAW_FLOOR;
  wire logic cl_block = cl_latch | current_limit_level;
  wire logic oc_done = (oc_state == bcp_pkg::BCP_FAULT)
      && (oc_cnt == '0) && !oc_trip;
  wire logic [5:0] high_mask = 6'b01_0101;
  wire logic hi_ok = pwm_on & ~below_floor & ~cl_block;
  wire logic [5:0] gate_chop = gate_raw
      & (hi_ok ? 6'b11_1111 : ~high_mask);
  wire logic [5:0] next_gate = in_fault ? 6'b00_0000 : gate_chop;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cl_latch <= 1'b0;
    end else if (current_limit_level) begin
      // A trip in the clearing cycle wins over the period clear
      cl_latch <= 1'b1;
    end else if (period_start) begin
      cl_latch <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      oc_state <= bcp_pkg::BCP_RUN;
      oc_cnt <= '0;
    end else begin
      case (oc_state)
        bcp_pkg::BCP_RUN: begin
          if (oc_trip) begin
            oc_state <= bcp_pkg::BCP_FAULT;
            oc_cnt <= ($bits(oc_cnt))'(OC_RECOVERY - 1);
          end
        end
        bcp_pkg::BCP_FAULT: begin
          if (oc_trip) begin
            oc_cnt <= ($bits(oc_cnt))'(OC_RECOVERY - 1);
          end else if (oc_cnt == '0) begin
            oc_state <= bcp_pkg::BCP_RUN;
          end else begin
            oc_cnt <= oc_cnt - 1'b1;
          end
        end
        default: oc_state <= bcp_pkg::BCP_RUN;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gate <= 6'b00_0000;
      tach_single_out <= 1'b0;
      tach_majority_out <= 1'b0;
      pwm_clock_monitor <= 1'b0;
      hall_invalid_q <= 1'b0;
    end else begin
      gate <= next_gate;
      tach_single_out <= tach_single;
      tach_majority_out <= tach_majority;
      pwm_clock_monitor <= period_start;
      hall_invalid_q <= hall_invalid;
    end
  end

  // Events
  logic [bcp_pkg::EV_W-1:0] ev;
  assign ev[bcp_pkg::EV_CL] = current_limit_level & ~cl_latch;
  assign ev[bcp_pkg::EV_OC] = oc_trip & (oc_state == bcp_pkg::BCP_RUN);
  assign ev[bcp_pkg::EV_OC_DONE] = oc_done;
  assign ev[bcp_pkg::EV_INVALID] = hall_invalid & ~hall_invalid_q;

  // AHB-Lite slave, zero wait states
  wire logic take = hsel & hready & htrans[1];
  wire logic wr_ctrl = wr_pend && wr_addr == bcp_pkg::OFF_CTRL;
  wire logic wr_speed = wr_pend && wr_addr == bcp_pkg::OFF_SPEED;
  wire logic wr_clr = wr_pend && wr_addr == bcp_pkg::OFF_IRQ_STAT;
  wire logic wr_mask = wr_pend && wr_addr == bcp_pkg::OFF_IRQ_MASK;
  wire logic [bcp_pkg::EV_W-1:0] clr_bits =
      wr_clr ? hwdata[bcp_pkg::EV_W-1:0] : '0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= take & hwrite;
      wr_addr <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= bcp_pkg::CTRL_RESET;
      speed_command <= bcp_pkg::SPEED_RESET[7:0];
      irq_mask <= '0;
      irq_stat <= '0;
    end else begin
      if (wr_ctrl) ctrl <= {31'h0000_0000, hwdata[0]};
      if (wr_speed) speed_command <= hwdata[7:0];
      if (wr_mask) irq_mask <= hwdata[bcp_pkg::EV_W-1:0];
      irq_stat <= (irq_stat & ~clr_bits) | ev;
    end
  end

  wire logic [31:0] status_word = {22'h00_0000, sawtooth_node,
      cl_latch, oc_state == bcp_pkg::BCP_FAULT};
  logic [31:0] rd_mux;
  always_comb begin
    case (haddr[7:0])
      bcp_pkg::OFF_CTRL: rd_mux = ctrl;
      bcp_pkg::OFF_SPEED: rd_mux = {24'h00_0000, speed_command};
      bcp_pkg::OFF_STATUS: rd_mux = status_word;
      bcp_pkg::OFF_IRQ_STAT: rd_mux = {28'h000_0000, irq_stat};
      bcp_pkg::OFF_IRQ_MASK: rd_mux = {28'h000_0000, irq_mask};
      bcp_pkg::OFF_GATES: rd_mux = {23'h00_0000, hall_a, hall_b, hall_c,
          gate};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (take & ~hwrite) begin
      hrdata <= rd_mux;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign irq = |(irq_stat & irq_mask);
endmodule : bcp_top

// *** design/bcp_pkg.sv ***
package bcp_pkg;
  // Clock and timing
  localparam int CLK_HZ = 50_000_000;
  localparam int CLK_PERIOD_NS = 20;
  localparam int OC_RECOVERY_US = 1000;
  localparam int OC_RECOVERY_CYC = OC_RECOVERY_US * (CLK_HZ / 1_000_000);
  localparam int PWM_HZ = 20_000;
  localparam int PWM_PERIOD_CYC = CLK_HZ / PWM_HZ;
  localparam int SPEED_W = 8;
  // Sawtooth floor and span in speed-command codes
  localparam logic [7:0] SAW_FLOOR = 8'h67;
  localparam logic [7:0] SAW_SPAN = 8'h98;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_SPEED = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h0C;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFF_GATES = 8'h14;

  // Control fields
  localparam int CTRL_OC_EN = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam logic [31:0] SPEED_RESET = 32'h0000_0000;

  // Event bit positions
  localparam int EV_CL = 0;
  localparam int EV_OC = 1;
  localparam int EV_OC_DONE = 2;
  localparam int EV_INVALID = 3;
  localparam int EV_W = 4;

  // Gate vector bit positions
  localparam int G_AH = 0;
  localparam int G_AL = 1;
  localparam int G_BH = 2;
  localparam int G_BL = 3;
  localparam int G_CH = 4;
  localparam int G_CL = 5;

  typedef enum logic [1:0] {
    BCP_RUN = 2'b01,
    BCP_FAULT = 2'b10
  } bcp_oc_state_t;
endpackage : bcp_pkg

// *** design/bcp_commutator.sv ***
`timescale 1ns/1ps
module bcp_commutator (
  input wire logic hall_a,
  input wire logic hall_b,
  input wire logic hall_c,
  output logic [5:0] gate_raw,
  output logic tach_single,
  output logic tach_majority,
  output logic hall_invalid
);
  wire logic [2:0] hall = {hall_a, hall_b, hall_c};

  always_comb begin
    gate_raw = 6'b00_0000;
    case (hall)
      3'b101: gate_raw = 6'b00_0110;
      3'b100: gate_raw = 6'b01_0010;
      3'b110: gate_raw = 6'b01_1000;
      3'b010: gate_raw = 6'b00_1001;
      3'b011: gate_raw = 6'b10_0001;
      3'b001: gate_raw = 6'b10_0100;
      default: gate_raw = 6'b00_0000;
    endcase
  end

  assign hall_invalid = (hall == 3'b000) || (hall == 3'b111);
  assign tach_single = hall_a;
  assign tach_majority = (hall_a & hall_b) | (hall_a & hall_c)
      | (hall_b & hall_c);
endmodule : bcp_commutator

// *** design/bcp_pwm.sv ***
`timescale 1ns/1ps
module bcp_pwm #(
  parameter int PERIOD = bcp_pkg::PWM_PERIOD_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [7:0] speed_command,
  output logic pwm_on,
  output logic period_start,
  output logic [7:0] sawtooth_node
);
  logic [$clog2(PERIOD)-1:0] cnt;
  logic [15:0] prod;
  wire logic last = (cnt == ($clog2(PERIOD))'(PERIOD - 1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= '0;
    end else if (last) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end

  // Ramp from floor to floor plus span over one period
  assign prod = 16'(32'(cnt) * 32'(bcp_pkg::SAW_SPAN) / PERIOD);
  assign sawtooth_node = bcp_pkg::SAW_FLOOR + prod[7:0];
  assign pwm_on = speed_command > sawtooth_node;
  assign period_start = (cnt == '0);
endmodule : bcp_pwm

// *** tb/bcp_motor_model.sv ***
`timescale 1ns/1ps
module bcp_motor_model (
  input wire logic hclk,
  input wire logic [2:0] code,
  input wire logic cl_req,
  input wire logic oc_req,
  input wire logic strap,
  input wire logic [5:0] gate,
  output logic hall_a = 1'b0,
  output logic hall_b = 1'b0,
  output logic hall_c = 1'b0,
  output logic current_limit_level = 1'b0,
  output logic overcurrent_level = 1'b0,
  output logic internal_rail = 1'b0
);
  always @(posedge hclk) begin
    {hall_a, hall_b, hall_c} <= code;
    // Shunt current only flows through a conducting high side
    current_limit_level <= cl_req & |(gate & 6'h15);
    overcurrent_level <= oc_req;
    internal_rail <= strap;
  end
endmodule : bcp_motor_model

// *** tb/bcp_top_properties.sv ***
`timescale 1ns/1ps
module bcp_top_checker #(
  parameter int OC_RECOVERY = 20,
  parameter int PWM_PERIOD = 50
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hall_a,
  input wire logic hall_b,
  input wire logic hall_c,
  input wire logic current_limit_level,
  input wire logic overcurrent_level,
  input wire logic internal_rail,
  input wire logic [5:0] gate,
  input wire logic tach_single_out,
  input wire logic tach_majority_out,
  input wire logic pwm_clock_monitor
);
  logic [7:0] qc;
  logic [15:0] pc;
  logic seen;
  wire logic [5:0] lows;
  wire logic maj;
  wire logic quiet;
  assign lows = {~hall_a & hall_c, 1'b0, hall_b & ~hall_c, 1'b0,
    hall_a & ~hall_b, 1'b0};
  assign maj = hall_a & hall_b | hall_b & hall_c | hall_a & hall_c;
  // Cycles since the last live over-current trip
  assign quiet = qc > OC_RECOVERY + 3;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) qc <= 8'h00;
    else if (overcurrent_level && !internal_rail) qc <= 8'h00;
    else if (qc != 8'hff) qc <= qc + 8'h01;
  end
  // Cycles since the last period pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pc <= 16'h0000;
      seen <= 1'b0;
    end else if (pwm_clock_monitor) begin
      pc <= 16'h0001;
      seen <= 1'b1;
    end else if (pc != 16'hffff) begin
      pc <= pc + 16'h0001;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_tach; 1 |=> tach_single_out == $past(hall_a) &&
    tach_majority_out == $past(maj); endproperty
  a_tach: assert property (p_tach) else $error("tach wrong");
  property p_inv; hall_a == hall_b && hall_b == hall_c |=> gate == 6'h00;
  endproperty
  a_inv: assert property (p_inv) else $error("bad hall drives");
  property p_low; quiet && !overcurrent_level |=>
    (gate & 6'h2a) == $past(lows); endproperty
  a_low: assert property (p_low) else $error("low side wrong");
  property p_cl; current_limit_level |=> (gate & 6'h15) == 6'h00; endproperty
  a_cl: assert property (p_cl) else $error("limit ignored");
  property p_oc; overcurrent_level && !internal_rail |=> gate == 6'h00;
  endproperty
  a_oc: assert property (p_oc) else $error("fault ignored");
  property p_rec; $fell(overcurrent_level) && !internal_rail |->
    (gate == 6'h00) [*8]; endproperty
  a_rec: assert property (p_rec) else $error("early recovery");
  property p_rail; internal_rail && overcurrent_level && quiet |=>
    (gate & 6'h2a) == $past(lows); endproperty
  a_rail: assert property (p_rail) else $error("strap ignored");
  property p_pwm; seen |-> pwm_clock_monitor == (pc == PWM_PERIOD);
  endproperty
  a_pwm: assert property (p_pwm) else $error("period wrong");
  c_cl: cover property (current_limit_level ##1 gate != 6'h00);
  c_oc: cover property ($fell(overcurrent_level) && !internal_rail);
  c_rail: cover property (internal_rail && overcurrent_level && quiet);
endmodule : bcp_top_checker
bind bcp_top bcp_top_checker #(.OC_RECOVERY(OC_RECOVERY),
  .PWM_PERIOD(PWM_PERIOD)) u_bcp_top_checker (.hclk, .hresetn, .hall_a,
  .hall_b, .hall_c, .current_limit_level, .overcurrent_level,
  .internal_rail, .gate, .tach_single_out, .tach_majority_out,
  .pwm_clock_monitor);

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  localparam int OCR = 20;
  localparam int PP = 50;
  typedef struct {logic [2:0] k; logic [31:0] v;} bcp_note_t;
  logic hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd_val, obs, spd;
  logic [1:0] htrans = 2'b00;
  logic [2:0] code = 3'b000, h;
  logic cl_req = 1'b0, oc_req = 1'b0, strap = 1'b0;
  logic hall_a, hall_b, hall_c, current_limit_level, overcurrent_level;
  logic internal_rail, hreadyout, hresp, irq, pcm, ts, tm;
  logic [5:0] gate;
  int num_errors = 0, check_count = 0, cyc = 0, e, dh, dl;
  bcp_note_t q[$], n;
  bcp_top #(.OC_RECOVERY(OCR), .PWM_PERIOD(PP)) u_bcp_top (.hclk,
    .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'b010),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .hall_a,
    .hall_b, .hall_c, .current_limit_level, .overcurrent_level,
    .internal_rail, .gate, .tach_single_out(ts), .tach_majority_out(tm),
    .pwm_clock_monitor(pcm), .irq);
  bcp_motor_model u_bcp_motor_model (.hclk, .code, .cl_req, .oc_req,
    .strap, .gate, .hall_a, .hall_b, .hall_c, .current_limit_level,
    .overcurrent_level, .internal_rail);
  initial forever #10 hclk = ~hclk;
  function automatic logic [5:0] dec(input logic [2:0] x, input logic hi);
    dec = {~x[2] & x[0], hi & x[2] & ~x[0], x[1] & ~x[0],
      hi & ~x[1] & x[0], x[2] & ~x[1], hi & ~x[2] & x[1]};
  endfunction : dec
  task automatic bus(input logic w, input logic [7:0] a, logic [31:0] d);
    @(posedge hclk);
    haddr <= {24'h0000_00, a};
    hwrite <= w;
    htrans <= 2'b10;
    @(posedge hclk iff hreadyout === 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk iff hreadyout === 1'b1);
    rd_val = hrdata;
    note(3'd5, 32'h0000_0002);
  endtask : bus
  task automatic note(input logic [2:0] k, input logic [31:0] v);
    q.push_back('{k, v});
  endtask : note
  task automatic hall(input logic [2:0] x);
    @(posedge hclk);
    code <= x;
    repeat (2) @(posedge hclk);
  endtask : hall
  task automatic pulse(input logic oc);
    @(posedge hclk iff pcm === 1'b1);
    if (oc) oc_req <= 1'b1;
    else cl_req <= 1'b1;
    @(posedge hclk);
    oc_req <= 1'b0;
    cl_req <= 1'b0;
    repeat (2) @(posedge hclk);
  endtask : pulse
  task automatic cmp_word(input logic [31:0] o, input logic [31:0] x);
    check_count++;
    if (o !== x) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, o, x);
    end
  endtask : cmp_word
  task automatic cmp_gate(input logic [5:0] o, input logic [5:0] x);
    cmp_word({26'h0, o}, {26'h0, x});
  endtask : cmp_gate
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish
  always @(negedge hclk) begin
    while (q.size() > 0) begin
      n = q.pop_front();
      obs = n.k == 3'd1 ? {30'h0, tm, ts} : n.k == 3'd2 ? rd_val :
        n.k == 3'd3 ? {31'h0, irq} :
        n.k == 3'd5 ? {30'h0, hreadyout, hresp} : (dl << 16) | dh;
      if (n.k == 3'd0) cmp_gate(gate, n.v[5:0]);
      else cmp_word(obs, n.v);
    end
  end
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  initial begin
    rd_val = $urandom(32'hc90b);
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b1, bcp_pkg::OFF_SPEED, 32'h0000_00ff);
    for (int i = 0; i < 16; i++) begin
      h = i < 8 ? i[2:0] : 3'($urandom_range(7));
      hall(h);
      note(3'd0, dec(h, 1'b1));
      note(3'd1, {h[2] & h[1] | h[1] & h[0] | h[2] & h[0], h[2]});
    end
    hall(3'b101);
    for (int i = 0; i < 4; i++) begin
      spd = i == 0 ? 32'h0000_0050 : $urandom_range(32'hff, 32'h67);
      bus(1'b1, bcp_pkg::OFF_SPEED, spd);
      e = 0;
      for (int c = 0; c < PP; c++)
        if (spd > bcp_pkg::SAW_FLOOR + c * bcp_pkg::SAW_SPAN / PP) e++;
      {dh, dl} = '0;
      @(posedge hclk iff pcm === 1'b1);
      repeat (PP) @(negedge hclk) {dh, dl} = {dh + gate[2], dl + gate[1]};
      note(3'd4, (PP << 16) | e);
    end
    bus(1'b1, bcp_pkg::OFF_SPEED, 32'h0000_00ff);
    pulse(1'b0);
    note(3'd0, dec(3'b101, 1'b0));
    repeat (PP / 2) @(posedge hclk);
    note(3'd0, dec(3'b101, 1'b0));
    @(posedge hclk iff pcm === 1'b1);
    repeat (3) @(posedge hclk);
    note(3'd0, dec(3'b101, 1'b1));
    pulse(1'b1);
    note(3'd0, 32'h0000_0000);
    repeat (OCR - 4) @(posedge hclk);
    note(3'd0, 32'h0000_0000);
    repeat (10) @(posedge hclk);
    note(3'd0, dec(3'b101, 1'b1));
    note(3'd3, 32'h0000_0000);
    bus(1'b1, bcp_pkg::OFF_IRQ_MASK, 32'h0000_0001 << bcp_pkg::EV_OC);
    note(3'd3, 32'h0000_0001);
    bus(1'b0, bcp_pkg::OFF_IRQ_STAT, 32'h0000_0000);
    note(3'd2, 32'h0000_000f);
    bus(1'b1, bcp_pkg::OFF_IRQ_STAT, 32'h0000_0002);
    note(3'd3, 32'h0000_0000);
    bus(1'b0, bcp_pkg::OFF_IRQ_STAT, 32'h0000_0000);
    note(3'd2, 32'h0000_000d);
    bus(1'b0, 8'h40, 32'h0000_0000);
    note(3'd2, 32'h0000_0000);
    bus(1'b0, bcp_pkg::OFF_CTRL, 32'h0000_0000);
    note(3'd2, 32'h0000_0001);
    bus(1'b0, bcp_pkg::OFF_GATES, 32'h0000_0000);
    note(3'd2, 32'h0000_0146);
    strap <= 1'b1;
    pulse(1'b1);
    note(3'd0, dec(3'b101, 1'b1));
    repeat (2) @(posedge hclk);
    tally_and_finish();
  end
endmodule : tb_top
